// *** rps_top.sv ***
// Peripheral pin-select slice: dead-time inputs and twelve output pins.
// Assumes an Avalon-MM master on clk; word-addressed, 16 bits in use.
`timescale 1ns/10ps
`default_nettype none
`include "rps_defs.svh"

module rps_top
  import rps_pkg::*;
#(
  parameter int IN_PINS = `RPS_IN_PIN_COUNT,
  parameter int FUNCS   = `RPS_FUNC_COUNT
)
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [3:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output var  logic [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic [IN_PINS-1:0]         remappable_pin_in,
  input  wire logic                       comparator_one_output,
  output var  logic [2:0]                 deadtime_comp_in,
  input  wire logic [FUNCS-1:0]           periph_func,
  output var  rps_outpin_s [`RPS_OUT_PINS-1:0] pin_drive
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  localparam int NREG = `RPS_REG_COUNT;

  rps_word_t    sel_r [NREG];
  rps_word_t    mask  [NREG];
  logic         ack_r;
  logic         req;
  logic         mapped;
  logic         wr_take;
  logic [2:0]   widx;
  rps_word_t    wr_word;

  always_comb
  begin
    mask[0] = `RPS_MASK_DTC1;
    mask[1] = `RPS_MASK_DTC23;
    for (int i = 2; i < NREG; i++)
    begin
      mask[i] = `RPS_MASK_OUT;
    end
  end

  // ------------------------------------------------------------
  // Avalon slave: one wait state per access
  // ------------------------------------------------------------
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign mapped          = (avs_address <= `RPS_IDX_OUT5);
  assign wr_take         = avs_write & ack_r & mapped;
  assign widx            = avs_address[2:0];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= req & ~ack_r;
    end
  end

  // Byte lanes above bit 15 have no storage
  always_comb
  begin
    wr_word = sel_r[widx];
    if (avs_byteenable[0])
    begin
      wr_word[7:0] = avs_writedata[7:0];
    end
    if (avs_byteenable[1])
    begin
      wr_word[15:8] = avs_writedata[15:8];
    end
    wr_word = wr_word & mask[widx];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        sel_r[i] <= `RPS_RESET_VALUE;
      end
    end
    else if (wr_take)
    begin
      sel_r[widx] <= wr_word;
    end
  end

  // Read data captured in the wait cycle, stands while ack is high
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      avs_readdata <= '0;
    end
    else if (avs_read & ~ack_r)
    begin
      if (mapped)
      begin
        avs_readdata <= {16'h0000, sel_r[widx] & mask[widx]};
      end
      else
      begin
        avs_readdata <= '0;
      end
    end
  end

  // ------------------------------------------------------------
  // Input routing to the dead-time compensation inputs
  // ------------------------------------------------------------
  rps_in_code_t in_code [3];

  assign in_code[0] =
    sel_r[0][`RPS_IN_HI_MSB:`RPS_IN_HI_LSB];
  assign in_code[1] = sel_r[1][`RPS_IN_LO_MSB:0];
  assign in_code[2] =
    sel_r[1][`RPS_IN_HI_MSB:`RPS_IN_HI_LSB];

  function automatic logic in_route(
    input rps_in_code_t         code,
    input logic [IN_PINS-1:0]   pins,
    input logic                 cmp
  );
    logic r;
    r = 1'b0;
    if (code == `RPS_CODE_GROUND)
    begin
      r = 1'b0;
    end
    else if (code == `RPS_CODE_COMP1)
    begin
      r = cmp;
    end
    else if (code <= `RPS_CODE_PIN_MAX)
    begin
      r = pins[code];
    end
    return r;
  endfunction

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      deadtime_comp_in <= '0;
    end
    else
    begin
      for (int k = 0; k < 3; k++)
      begin
        deadtime_comp_in[k] <= in_route(in_code[k], remappable_pin_in,
                                        comparator_one_output);
      end
    end
  end

  // ------------------------------------------------------------
  // Output routing: pins 20,35..43,54,55 in ascending order
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `RPS_OUT_PINS; g++)
    begin : g_out
      rps_func_t fsel;
      // Even index lower field, odd index upper field
      if (g % 2 == 0)
      begin : g_lo
        assign fsel =
          sel_r[2 + g/2][`RPS_OUT_LO_MSB:0];
      end
      else
      begin : g_hi
        assign fsel = sel_r[2 + g/2]
          [`RPS_OUT_HI_MSB:`RPS_OUT_HI_LSB];
      end
      // Registers 5..7 map pins 40..43 and 54,55
      rps_out_mux #(.FUNCS(FUNCS)) u_mux (
        .clk         (clk),
        .reset       (reset),
        .func_sel    (fsel),
        .periph_func (periph_func),
        .pin_drive   (pin_drive[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic [5:0] fn35;
  logic [5:0] fn20;
  logic [5:0] fn55;
  assign fn35 = sel_r[2][`RPS_OUT_HI_MSB:`RPS_OUT_HI_LSB];
  assign fn20 = sel_r[2][`RPS_OUT_LO_MSB:0];
  assign fn55 = sel_r[7][`RPS_OUT_HI_MSB:`RPS_OUT_HI_LSB];

  // ------------------------------------------------------------
  // Bus handshake and register checks
  // ------------------------------------------------------------
  wait_one_a: assert property (
    req & ~ack_r |-> avs_waitrequest ##1 (~avs_waitrequest | ~req))
    else $error("bus answer not after one wait state");

  ack_pulse_a: assert property (
    ack_r |=> ~ack_r)
    else $error("bus acknowledge held longer than one cycle");

  rsv_zero_a: assert property (
    avs_read & ~avs_waitrequest |-> avs_readdata[31:16] == 16'h0000 &&
    (avs_readdata[15:0] & ~mask[widx]) == 16'h0000)
    else $error("unimplemented bits read nonzero");

  unmapped_zero_a: assert property (
    avs_read & ~avs_waitrequest & ~mapped |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped word read nonzero");

  wr_drop_a: assert property (
    wr_take & avs_byteenable[1:0] == 2'b11
    |=> sel_r[$past(widx)] == ($past(avs_writedata[15:0]) &
        mask[$past(widx)]))
    else $error("write not stored under mask");

  lane_keep_a: assert property (
    wr_take & avs_byteenable[1:0] == 2'b01
    |=> sel_r[$past(widx)][15:8] == $past(sel_r[widx][15:8]))
    else $error("disabled byte lane overwritten");

  reset_clear_a: assert property (
    $past(reset) |-> sel_r[0] == 16'h0000 && sel_r[1] == 16'h0000 &&
    sel_r[2] == 16'h0000 && sel_r[7] == 16'h0000)
    else $error("selectors not cleared by reset");

  // ------------------------------------------------------------
  // Input routing checks
  // ------------------------------------------------------------
  dtc1_ground_a: assert property (
    in_code[0] == `RPS_CODE_GROUND |=> deadtime_comp_in[0] == 1'b0)
    else $error("input 1 not tied low for code zero");

  dtc1_comp_a: assert property (
    sel_r[0][14:8] == `RPS_CODE_COMP1
    |=> deadtime_comp_in[0] == $past(comparator_one_output))
    else $error("input 1 not following comparator");

  dtc1_refuse_a: assert property (
    sel_r[0][14:8] > `RPS_CODE_PIN_MAX |=> deadtime_comp_in[0] == 1'b0)
    else $error("input 1 not low for an undefined code");

  dtc2_comp_a: assert property (
    sel_r[1][6:0] == `RPS_CODE_COMP1
    |=> deadtime_comp_in[1] == $past(comparator_one_output))
    else $error("input 2 not following comparator");

  dtc2_pin_a: assert property (
    sel_r[1][6:0] == `RPS_CODE_PIN_MAX
    |=> deadtime_comp_in[1] == $past(remappable_pin_in[121]))
    else $error("input 2 not following pin 121");

  dtc3_ground_a: assert property (
    sel_r[1][14:8] == `RPS_CODE_GROUND |=> deadtime_comp_in[2] == 1'b0)
    else $error("input 3 not tied low for code zero");

  dtc3_pin_a: assert property (
    sel_r[1][14:8] == `RPS_CODE_PIN_MAX
    |=> deadtime_comp_in[2] == $past(remappable_pin_in[121]))
    else $error("input 3 not following pin 121");

  // ------------------------------------------------------------
  // Output routing checks
  // ------------------------------------------------------------
  pin20_func_a: assert property (
    1'b1 |=> pin_drive[0].en == ($past(fn20) != 6'h00))
    else $error("pin 20 enable wrong");

  pin35_func_a: assert property (
    1'b1 |=> pin_drive[1].en == ($past(fn35) != 6'h00) &&
    pin_drive[1].level == ($past(fn35) != 6'h00 &
                           $past(periph_func[fn35])))
    else $error("pin 35 not driven by its function");

  pin36_func_a: assert property (
    1'b1 |=> pin_drive[2].en == ($past(sel_r[3][5:0]) != 6'h00))
    else $error("pin 36 enable wrong");

  pin37_func_a: assert property (
    1'b1 |=> pin_drive[3].en == ($past(sel_r[3][13:8]) != 6'h00))
    else $error("pin 37 enable wrong");

  pin39_func_a: assert property (
    1'b1 |=> pin_drive[5].en == ($past(sel_r[4][13:8]) != 6'h00))
    else $error("pin 39 enable wrong");

  pin40_func_a: assert property (
    1'b1 |=> pin_drive[6].en == ($past(sel_r[5][5:0]) != 6'h00))
    else $error("pin 40 enable wrong");

  pin43_func_a: assert property (
    1'b1 |=> pin_drive[9].en == ($past(sel_r[6][13:8]) != 6'h00))
    else $error("pin 43 enable wrong");

  pin54_func_a: assert property (
    1'b1 |=> pin_drive[10].en == ($past(sel_r[7][5:0]) != 6'h00))
    else $error("pin 54 enable wrong");

  pin55_func_a: assert property (
    1'b1 |=> pin_drive[11].level == ($past(fn55) != 6'h00 &
                                    $past(periph_func[fn55])))
    else $error("pin 55 not driven by its function");

  cov_write_c: cover property (wr_take ##2 avs_read & ~avs_waitrequest);
  cov_pin121_c: cover property (in_code[2] == `RPS_CODE_PIN_MAX);
  cov_unmapped_c: cover property (avs_read & ~mapped & ack_r);
  cov_func_c: cover property (pin_drive[11].en);
  cov_lane_c: cover property (wr_take & avs_byteenable[1:0] == 2'b01);

endmodule // rps_top

`default_nettype wire

// *** rps_defs.svh ***
// Offsets, field positions, masks and codes of the pin-select block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef RPS_DEFS_SVH
`define RPS_DEFS_SVH

// Register word indices on the bus
`define RPS_IDX_DTC1      4'h0
`define RPS_IDX_DTC23     4'h1
`define RPS_IDX_OUT0      4'h2
`define RPS_IDX_OUT5      4'h7
`define RPS_REG_COUNT     8

// Implemented bits of each register
`define RPS_MASK_DTC1     16'h7F00
`define RPS_MASK_DTC23    16'h7F7F
`define RPS_MASK_OUT      16'h3F3F
`define RPS_RESET_VALUE   16'h0000

// Field positions
`define RPS_IN_HI_MSB     14
`define RPS_IN_HI_LSB     8
`define RPS_IN_LO_MSB     6
`define RPS_OUT_HI_MSB    13
`define RPS_OUT_HI_LSB    8
`define RPS_OUT_LO_MSB    5

// Input selector codes
`define RPS_CODE_GROUND   7'h00
`define RPS_CODE_COMP1    7'h01
`define RPS_CODE_PIN_MAX  7'h79
`define RPS_IN_PIN_COUNT  122

// Output pins and peripheral functions
`define RPS_OUT_PINS      12
`define RPS_FUNC_COUNT    64
`define RPS_FUNC_NONE     6'h00

`endif

// *** rps_pkg.sv ***
// Types shared by the pin-select block.
// Assumes rps_defs.svh is on the include path.
`include "rps_defs.svh"

package rps_pkg;
  typedef logic [6:0]  rps_in_code_t;
  typedef logic [5:0]  rps_func_t;
  typedef logic [15:0] rps_word_t;

  typedef struct packed {
    logic en;
    logic level;
  } rps_outpin_s;
endpackage

// *** rps_out_mux.sv ***
// One remappable output pin: routes a peripheral function to the pin.
// Assumes function number zero leaves the pin to its port latch.
`timescale 1ns/10ps
`default_nettype none
`include "rps_defs.svh"

module rps_out_mux
  import rps_pkg::*;
#(
  parameter int FUNCS = `RPS_FUNC_COUNT
)
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire rps_func_t         func_sel,
  input  wire logic [FUNCS-1:0]  periph_func,
  output var  rps_outpin_s       pin_drive
);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_drive <= '0;
    end
    else
    begin
      pin_drive.en    <= (func_sel != `RPS_FUNC_NONE);
      pin_drive.level <= (func_sel != `RPS_FUNC_NONE) &
                         periph_func[func_sel];
    end
  end

endmodule // rps_out_mux

`default_nettype wire

// *** rps_far_side.sv ***
// Model of the device pins, comparator 1 and peripheral outputs.
// Assumes the bench drives flip at the rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module rps_far_side
  import rps_pkg::*;
#(
  parameter logic [121:0] PIN_PAT  = '0,
  parameter logic [63:0]  FUNC_PAT = '0
)
(
  input  wire logic          flip,
  output logic [121:0]       pins,
  output logic               cmp,
  output logic [63:0]        funcs
);
  // Flip inverts every level so stale routing shows
  assign pins  = flip ? ~PIN_PAT : PIN_PAT;
  assign cmp   = flip;
  assign funcs = flip ? ~FUNC_PAT : FUNC_PAT;
endmodule // rps_far_side

`default_nettype wire

// *** remappable_pin_select_bench.sv ***
// Self-checking bench of the pin-select slice.
// Assumes rps_top, rps_far_side and rps_defs.svh are compiled.
`timescale 1ns/10ps
`default_nettype none
`include "rps_defs.svh"

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end

module remappable_pin_select_bench
  import rps_pkg::*;
;
  localparam logic [121:0] PIN_PAT  = {61{2'b10}};
  localparam logic [63:0]  FUNC_PAT = {16{4'b1100}};
  logic                           clk, reset, avs_read, avs_write, flip;
  logic [3:0]                     avs_address, avs_byteenable;
  logic [31:0]                    avs_writedata, avs_readdata;
  logic                           avs_waitrequest, cmp;
  logic [121:0]                   pins;
  logic [63:0]                    funcs;
  logic [2:0]                     dtc;
  rps_outpin_s [`RPS_OUT_PINS-1:0] pin_drive;
  int                             failures, compares;
  rps_in_code_t codes [5] = '{7'h00, 7'h01, 7'h3C, 7'h79, 7'h7F};

  rps_top i_rps_top (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .remappable_pin_in(pins), .comparator_one_output(cmp),
    .deadtime_comp_in(dtc), .periph_func(funcs), .pin_drive(pin_drive));

  rps_far_side #(.PIN_PAT(PIN_PAT), .FUNC_PAT(FUNC_PAT)) i_rps_far_side
    (.flip(flip), .pins(pins), .cmp(cmp), .funcs(funcs));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----
  // Bus cycles
  // ----
  task automatic xfer(input logic we, input logic [3:0] a,
                      input rps_word_t d, input logic [3:0] be,
                      output rps_word_t q);
    @(posedge clk);
    avs_read       <= !we;
    avs_write      <= we;
    avs_address    <= a;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= be;
    // Hold until waitrequest is seen low at a rising edge
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input rps_word_t d);
    rps_word_t q;
    xfer(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd_chk(input logic [3:0] a, input rps_word_t e);
    rps_word_t q;
    xfer(1'b0, a, 16'h0000, 4'hF, q);
    `CHK(q, e)
  endtask

  function automatic rps_word_t mask_of(input int i);
    return i == 0 ? `RPS_MASK_DTC1 : i == 1 ? `RPS_MASK_DTC23 :
           i < 8 ? `RPS_MASK_OUT : 16'h0000;
  endfunction

  // ----
  // Scenarios
  // ----
  task automatic test_regs();
    for (int i = 0; i < 16; i++)
      rd_chk(i[3:0], 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      wr(i[3:0], 16'hFFFF);
      rd_chk(i[3:0], mask_of(i));
    end
  endtask

  task automatic test_lanes();
    rps_word_t q;
    xfer(1'b1, 4'h3, 16'hFFFF, 4'h1, q);
    rd_chk(4'h3, 16'h003F);
    xfer(1'b1, 4'h3, 16'hFFFF, 4'h2, q);
    rd_chk(4'h3, 16'h3F3F);
    xfer(1'b1, 4'h3, 16'h0000, 4'h1, q);
    rd_chk(4'h3, 16'h3F00);
  endtask

  task automatic test_reset();
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++)
      rd_chk(i[3:0], 16'h0000);
    `CHK(dtc, 3'b000)
  endtask

  task automatic route_in(input int which, input rps_in_code_t code);
    logic e;
    wr(which == 0 ? 4'h0 : 4'h1,
       which == 1 ? {9'h000, code} : {1'b0, code, 8'h00});
    for (int f = 0; f < 2; f++)
    begin
      @(posedge clk);
      flip <= f[0];
      repeat (2) @(posedge clk);
      #1;
      e = code == 0 ? 1'b0 : code == 1 ? f[0] :
          code <= 121 ? PIN_PAT[code] ^ f[0] : 1'b0;
      `CHK(dtc, 3'({2'b00, e} << which))
    end
  endtask

  task automatic route_out(input int i, input rps_func_t fn);
    rps_outpin_s e;
    wr(4'(2 + i / 2), i % 2 ? {2'b00, fn, 8'h00} : {10'h000, fn});
    for (int f = 0; f < 2; f++)
    begin
      @(posedge clk);
      flip <= f[0];
      repeat (2) @(posedge clk);
      #1;
      e.en    = fn != 0;
      e.level = e.en & (FUNC_PAT[fn] ^ f[0]);
      `CHK(pin_drive[i], e)
    end
  endtask

  task automatic end_sim();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    end_sim();
  end

  initial
  begin
    reset          = 1'b1;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_address    = 4'h0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
    flip           = 1'b0;
    failures       = 0;
    compares       = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    test_regs();
    test_reset();
    test_lanes();
    for (int w = 0; w < 3; w++)
      foreach (codes[c])
        route_in(w, codes[c]);
    route_out(0, 6'h01);
    route_out(1, 6'h3F);
    route_out(2, 6'h02);
    route_out(3, 6'h05);
    route_out(4, 6'h11);
    route_out(5, 6'h22);
    route_out(6, 6'h2A);
    route_out(7, 6'h15);
    route_out(8, 6'h30);
    route_out(9, 6'h0C);
    route_out(10, 6'h3E);
    route_out(11, 6'h07);
    route_out(1, 6'h00);
    end_sim();
  end
endmodule // remappable_pin_select_bench

`default_nettype wire
